// File: core/magnitude_sign_comparator.v
// 16-bit magnitude, sign and equality of a minus b
// purely combinational; the caller registers the results
`timescale 1ns/100ps
module magnitude_sign_comparator (
  input  wire [15:0] opA,
  input  wire [15:0] opB,
  output reg  [15:0] magnitude,
  output reg  [7:0]  signCode,
  output reg         equal
);
  reg [8:0]  lowDiff;
  reg [8:0]  highDiff;
  reg [15:0] rawDiff;

  always @* begin
    // low byte first, borrow carried into the high byte
    lowDiff  = {1'b0, opA[7:0]} - {1'b0, opB[7:0]};
    highDiff = {1'b0, opA[15:8]} - {1'b0, opB[15:8]}
               - {8'h00, lowDiff[8]};
    rawDiff  = {highDiff[7:0], lowDiff[7:0]};
    equal    = (rawDiff == 16'h0000);
    if (highDiff[8]) begin
      signCode  = 8'hFF;
      magnitude = ~rawDiff + 16'h0001;
    end else begin
      signCode  = 8'h00;
      magnitude = rawDiff;
    end
  end
endmodule // magnitude_sign_comparator

// File: core/position_error_direction_unit.v
// position error and drive direction unit for one focus or rotation axis
// assumes an apb master on the register side and an apex interface that
// clears its data word on apexRequest and then shows 2'b10 in the top bits
`timescale 1ns/100ps
`include "position_error_direction_unit_regs.vh"
module position_error_direction_unit #(
  parameter [3:0] POLL_COUNT = `PED_POLL_COUNT
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        ce,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // apex interface
  output reg         apexRequest,
  input  wire [15:0] apexData,
  // drive side
  output reg         apexFault,
  output reg         driveDirection,
  output reg         inPosition,
  output reg         commandActive
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ  = 2'h1;
  localparam [1:0] ST_POLL = 2'h2;
  localparam [1:0] ST_CALC = 2'h3;

  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [3:0]  pollCnt_ff;
  reg [3:0]  nxt_pollCnt;
  reg [15:0] setPoint_ff;
  reg [15:0] posMon_ff;
  reg [13:0] posInt_ff;
  reg [15:0] errValue_ff;
  reg        errSign_ff;
  reg        errZero_ff;
  reg        dirLatch_ff;
  reg        auto_ff;
  reg        acqPend_ff;
  reg        nxt_acqPend;

  wire        apbWrite;
  wire        apbSetup;
  wire        ctrlWrite;
  wire        setPointWrite;
  wire        apexValid;
  wire [15:0] curPos;
  wire [15:0] errMag;
  wire [7:0]  errSignCode;
  wire        errEqual;
  wire [15:0] vecMag;
  wire [7:0]  vecSignCode;
  wire        vecDecide;
  wire        vecDir;
  wire        inPosNow;

  // write takes effect only at the completing access edge
  assign apbWrite      = psel & penable & pready & pwrite;
  assign apbSetup      = psel & ~penable;
  assign ctrlWrite     = apbWrite & (paddr == `PED_CTRL_OFS);
  assign setPointWrite = apbWrite & (paddr == `PED_SETPOINT_OFS);
  assign apexValid     = (apexData[`PED_VALID_HI:`PED_VALID_LO]
                          == `PED_VALID_PATTERN);
  assign curPos        = {2'h0, posInt_ff};

  // error as current minus commanded position
  magnitude_sign_comparator errCmp (
    .opA       (curPos),
    .opB       (setPoint_ff),
    .magnitude (errMag),
    .signCode  (errSignCode),
    .equal     (errEqual)
  );

  // direction works on destination minus present position
  magnitude_sign_comparator vecCmp (
    .opA       (setPoint_ff),
    .opB       (curPos),
    .magnitude (vecMag),
    .signCode  (vecSignCode),
    .equal     ()
  );

  shortest_direction_select dirSel (
    .magnitude (vecMag),
    .signCode  (vecSignCode),
    .decide    (vecDecide),
    .direction (vecDir),
    .zeroMag   ()
  );

  // high byte nonzero rules in-position out at once
  assign inPosNow = (errMag[15:8] == 8'h00) &&
                    (errMag[7:0] < `PED_INPOS_LIMIT);

  // acquisition sequencer
  always @* begin
    nxt_state   = state_ff;
    nxt_pollCnt = pollCnt_ff;
    nxt_acqPend = acqPend_ff;
    if (ctrlWrite && pwdata[`PED_CTRL_ACQUIRE]) begin
      nxt_acqPend = 1'b1;
    end
    case (state_ff)
      ST_IDLE: begin
        if (acqPend_ff || auto_ff) begin
          nxt_state   = ST_REQ;
          nxt_acqPend = 1'b0;
        end
      end
      ST_REQ: begin
        nxt_state   = ST_POLL;
        nxt_pollCnt = POLL_COUNT;
      end
      ST_POLL: begin
        if (apexValid) begin
          nxt_state = ST_CALC;
        end else if (pollCnt_ff == 4'h1) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_pollCnt = pollCnt_ff - 4'h1;
        end
      end
      ST_CALC: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      pollCnt_ff  <= 4'h0;
      acqPend_ff  <= 1'b0;
      apexRequest <= 1'b0;
    end else if (ce) begin
      state_ff    <= nxt_state;
      pollCnt_ff  <= nxt_pollCnt;
      acqPend_ff  <= nxt_acqPend;
      // one-cycle strobe; the apex side clears its word on it
      apexRequest <= (nxt_state == ST_REQ);
    end
  end

  // position capture and fault flag
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      posMon_ff <= `PED_POS_RST;
      posInt_ff <= 14'h0000;
      apexFault <= 1'b0;
    end else if (ce && state_ff == ST_POLL) begin
      if (apexValid) begin
        apexFault <= 1'b0;
        posMon_ff <= apexData & `PED_POS_MASK;
        posInt_ff <= apexData[13:0];
      end else if (pollCnt_ff == 4'h1) begin
        // stored position stays as it was for this pass
        apexFault <= 1'b1;
      end
    end
  end

  // error and sign after each good acquisition, direction after each one with a nonzero error
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      errValue_ff <= 16'h0000;
      errSign_ff  <= 1'b0;
      errZero_ff  <= 1'b1;
      dirLatch_ff <= 1'b0;
      inPosition  <= 1'b0;
    end else if (ce && state_ff == ST_CALC) begin
      // done whether or not a command is running
      errValue_ff <= errMag;
      errSign_ff  <= errSignCode[0];
      errZero_ff  <= errEqual;
      inPosition  <= inPosNow;
      if (vecDecide) begin
        dirLatch_ff <= vecDir;
      end
    end
  end

  // command state; a new command takes the latched direction
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      commandActive  <= 1'b0;
      driveDirection <= 1'b0;
      auto_ff        <= 1'b0;
    end else if (ce) begin
      if (ctrlWrite) begin
        auto_ff <= pwdata[`PED_CTRL_AUTO];
      end
      if (ctrlWrite && pwdata[`PED_CTRL_CMD_START]) begin
        commandActive  <= 1'b1;
        driveDirection <= dirLatch_ff;
      end else if (ctrlWrite && pwdata[`PED_CTRL_CMD_STOP]) begin
        commandActive <= 1'b0;
      end else if (state_ff == ST_CALC && commandActive && inPosNow) begin
        commandActive <= 1'b0;
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setPoint_ff <= `PED_SETPOINT_RST;
    end else if (ce && setPointWrite) begin
      // set point lives on the 14-bit circle
      setPoint_ff <= pwdata[15:0] & `PED_POS_MASK;
    end
  end

  // apb answer: data and ready registered in the setup cycle, so every
  // access completes at its first access edge with no wait state
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (apbSetup) begin
        pready  <= 1'b1;
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
        case (paddr)
          `PED_CTRL_OFS: begin
            prdata <= 32'h00000000;
          end
          `PED_SETPOINT_OFS: begin
            prdata <= {16'h0000, setPoint_ff};
          end
          `PED_STATUS_OFS: begin
            prdata[`PED_ST_FAULT]      <= apexFault;
            prdata[`PED_ST_DIR]        <= dirLatch_ff;
            prdata[`PED_ST_INPOS]      <= inPosition;
            prdata[`PED_ST_BUSY]       <= (state_ff != ST_IDLE);
            prdata[`PED_ST_ZERO]       <= errZero_ff;
            prdata[`PED_ST_SIGN]       <= errSign_ff;
            prdata[`PED_ST_CMD_ACTIVE] <= commandActive;
            prdata[`PED_ST_ACT_DIR]    <= driveDirection;
            prdata[`PED_ST_AUTO]       <= auto_ff;
          end
          `PED_POS_MON_OFS: begin
            prdata <= {16'h0000, posMon_ff};
          end
          `PED_POS_INT_OFS: begin
            prdata <= {18'h00000, posInt_ff};
          end
          `PED_ERR_VALUE_OFS: begin
            prdata <= {16'h0000, errValue_ff};
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule // position_error_direction_unit

// File: core/position_error_direction_unit_regs.vh
// register offsets, field positions, reset values and counts of the
// position error and direction unit
// assumes byte addresses on a 32-bit apb bus, one word per register
`ifndef POSITION_ERROR_DIRECTION_UNIT_REGS_VH
`define POSITION_ERROR_DIRECTION_UNIT_REGS_VH

// register byte offsets
`define PED_CTRL_OFS        8'h00
`define PED_SETPOINT_OFS    8'h04
`define PED_STATUS_OFS      8'h08
`define PED_POS_MON_OFS     8'h0C
`define PED_POS_INT_OFS     8'h10
`define PED_ERR_VALUE_OFS   8'h14

// control register bits (write only, self clearing except auto, which holds)
`define PED_CTRL_ACQUIRE    0
`define PED_CTRL_AUTO       1
`define PED_CTRL_CMD_START  2
`define PED_CTRL_CMD_STOP   3

// status register bits
`define PED_ST_FAULT        0
`define PED_ST_DIR          1
`define PED_ST_INPOS        2
`define PED_ST_BUSY         3
`define PED_ST_ZERO         4
`define PED_ST_SIGN         5
`define PED_ST_CMD_ACTIVE   6
`define PED_ST_ACT_DIR      7
`define PED_ST_AUTO         8

// reset values
`define PED_SETPOINT_RST    16'h0000
`define PED_POS_RST         16'h0000

// apex word layout and counts
`define PED_VALID_HI        15
`define PED_VALID_LO        14
`define PED_VALID_PATTERN   2'h2
`define PED_POS_MASK        16'h3FFF
`define PED_POLL_COUNT      4'hA
`define PED_HALF_RANGE      16'h2000
`define PED_INPOS_LIMIT     8'h03

`endif

// File: core/shortest_direction_select.v
// picks the shorter way round the wrapping position circle
// expects magnitude and sign of (destination - present position)
`timescale 1ns/100ps
`include "position_error_direction_unit_regs.vh"
module shortest_direction_select (
  input  wire [15:0] magnitude,
  input  wire [7:0]  signCode,
  output reg         decide,
  output reg         direction,
  output reg         zeroMag
);
  reg [16:0] probe;

  always @* begin
    probe     = {1'b0, magnitude} + {1'b0, (~`PED_HALF_RANGE + 16'h0001)};
    zeroMag   = (magnitude == 16'h0000);
    // no decision at all for a zero error
    decide    = ~zeroMag;
    if (!probe[16]) begin
      // under half the range: the direct path is shorter
      direction = signCode[0];
    end else begin
      // half the range or more: go through the wrap point instead
      direction = ~signCode[0];
    end
  end
endmodule // shortest_direction_select

// File: sim/apex_word_model.sv
// apex interface model: clears its word on request unless delay is 1, shows it valid later
// delay is the poll number that first sees the valid word
`timescale 1ns/100ps
module apex_word_model (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        apexRequest,
  input  wire [13:0] pos,
  input  wire [4:0]  delay,
  output wire [15:0] apexData
);
  logic [4:0]  cnt_ff;
  logic [15:0] word_ff;
  assign apexData = word_ff;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 5'h00;
      word_ff <= 16'h0000;
    end else if (apexRequest) begin
      cnt_ff <= delay;
      word_ff <= (delay == 5'h01) ? {2'b10, pos} : 16'h0000;
    end else if (cnt_ff != 5'h00) begin
      cnt_ff <= cnt_ff - 5'h01;
      if (cnt_ff == 5'h02)
        word_ff <= {2'b10, pos};
    end
  end
endmodule // apex_word_model

// File: sim/position_error_direction_unit_checker.sv
// port checker for the position error and direction unit
// assumes the bench keeps ce high and uses aligned offsets only
`timescale 1ns/100ps
module position_error_direction_unit_checker #(
  parameter [3:0] POLL_COUNT = 4'hA
) (
  input wire        clock,
  input wire        rst_n,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        apexRequest,
  input wire [15:0] apexData,
  input wire        apexFault,
  input wire        driveDirection,
  input wire        inPosition,
  input wire        commandActive
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_startCmd;
    pready && pwrite && paddr == 8'h00 && pwdata[2];
  endsequence
  property p_readyPulse;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_readyPulse: assert property (p_readyPulse) else $error("pready timing");
  property p_unmapped;
    pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped answer");
  property p_reqSpacing;
    apexRequest |=> !apexRequest [*3];
  endproperty
  a_reqSpacing: assert property (p_reqSpacing) else $error("request pulse");
  property p_faultAfterPolls;
    $rose(apexFault) |-> $past(apexRequest, POLL_COUNT + 1);
  endproperty
  a_faultAfterPolls: assert property (p_faultAfterPolls)
    else $error("fault timing");
  property p_faultClear;
    $fell(apexFault) |-> $past(apexData[15:14], 1) == 2'b10 ||
                         $past(apexData[15:14], 2) == 2'b10;
  endproperty
  a_faultClear: assert property (p_faultClear) else $error("fault cleared");
  property p_errUpdate;
    $changed(inPosition) |-> $past(apexData[15:14], 2) == 2'b10;
  endproperty
  a_errUpdate: assert property (p_errUpdate) else $error("band update");
  property p_cmdStart;
    s_startCmd |=> commandActive;
  endproperty
  a_cmdStart: assert property (p_cmdStart) else $error("command start");
  property p_dirLatch;
    $changed(driveDirection) |->
      $past(pready && pwrite && paddr == 8'h00 && pwdata[2]);
  endproperty
  a_dirLatch: assert property (p_dirLatch) else $error("direction load");
endmodule // position_error_direction_unit_checker

bind position_error_direction_unit position_error_direction_unit_checker
  #(.POLL_COUNT(POLL_COUNT)) i_chk (.clock(clock), .rst_n(rst_n), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .apexRequest(apexRequest), .apexData(apexData), .apexFault(apexFault),
  .driveDirection(driveDirection), .inPosition(inPosition),
  .commandActive(commandActive));

// File: sim/tb.sv
// self-checking bench: apb register tests against the apex model
// assumes answers and acquisitions as in the hand-over timing
`timescale 1ns/100ps
`include "position_error_direction_unit_regs.vh"
module tb;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic        apexRequest, apexFault, driveDirection, inPosition;
  logic        commandActive, sgn, dir, fault;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] apexData, mag, cur, sp, lastCur;
  logic [13:0] apexPos;
  logic [4:0]  apexDly;
  int          fails, total_checks;
  int          cycles = 0;
  logic [15:0] curT [7] = '{16'h3000, 16'h0100, 16'h0105, 16'h0200,
                            16'h0102, 16'h0200, 16'h0100};
  logic [15:0] spT [7] = '{16'h0100, 16'h0102, 16'h0102, 16'h0100,
                           16'h0102, 16'h0100, 16'h2100};
  logic [4:0]  dlyT [7] = '{5'h02, 5'h0A, 5'h01, 5'h0B, 5'h03, 5'h04, 5'h05};

  position_error_direction_unit i_position_error_direction_unit (
    .clock(clock), .rst_n(rst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .apexRequest(apexRequest), .apexData(apexData), .apexFault(apexFault),
    .driveDirection(driveDirection), .inPosition(inPosition),
    .commandActive(commandActive));
  apex_word_model i_apex_word_model (.clock(clock), .rst_n(rst_n),
    .apexRequest(apexRequest), .pos(apexPos), .delay(apexDly),
    .apexData(apexData));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end

  task check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // holds the request until pready is seen at a rising edge, or for at most 20 edges
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a slave that never answers counts against the run
    if (pready !== 1'b1)
      fails++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
    {apexPos, fails, total_checks, lastCur, mag, dir} = '0;
    {sgn, fault} = '0;
    apexDly = 5'h01;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `PED_SETPOINT_OFS, 32'h0);
    check("setpoint reset", r, 32'h0);
    apb(1'b0, `PED_STATUS_OFS, 32'h0);
    // both positions reset to zero, so the error-zero bit starts set
    check("status reset", r, 32'h10);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", r, 32'h0);
    apb(1'b1, `PED_SETPOINT_OFS, 32'hFFFF);
    apb(1'b0, `PED_SETPOINT_OFS, 32'h0);
    check("setpoint mask", r, 32'h3FFF);
    for (int i = 0; i < 7; i++) begin
      cur = curT[i];
      sp = spT[i];
      apexPos <= cur[13:0];
      apexDly <= dlyT[i];
      apb(1'b1, `PED_SETPOINT_OFS, {16'h0, sp});
      apb(1'b1, `PED_CTRL_OFS, 32'h1);
      repeat (16) @(posedge clock);
      fault = dlyT[i] > 5'h0A;
      if (!fault) begin
        mag = (cur > sp) ? cur - sp : sp - cur;
        sgn = cur < sp;
        if (mag != 16'h0)
          dir = (sp < cur) ^ (mag >= 16'h2000);
        lastCur = cur;
      end
      apb(1'b0, `PED_ERR_VALUE_OFS, 32'h0);
      check("error value", r, {16'h0, mag});
      apb(1'b0, `PED_POS_INT_OFS, 32'h0);
      check("position", r, {16'h0, lastCur});
      apb(1'b0, `PED_POS_MON_OFS, 32'h0);
      check("monitor position", r, {16'h0, lastCur});
      apb(1'b0, `PED_STATUS_OFS, 32'h0);
      check("status", r & 32'h37, {26'h0, sgn, mag == 16'h0, 1'b0,
                                   mag < 16'h3, dir, fault});
      check("fault pin", {31'h0, apexFault}, {31'h0, fault});
      check("band pin", {31'h0, inPosition}, {31'h0, mag < 16'h3});
    end
    apb(1'b1, `PED_CTRL_OFS, 32'h2);
    repeat (20) @(posedge clock);
    apb(1'b0, `PED_STATUS_OFS, 32'h0);
    check("auto bit", r & 32'h101, 32'h100);
    apb(1'b1, `PED_CTRL_OFS, 32'h0);
    repeat (20) @(posedge clock);
    apb(1'b0, `PED_ERR_VALUE_OFS, 32'h0);
    check("auto error value", r, {16'h0, mag});
    apb(1'b1, `PED_CTRL_OFS, 32'h4);
    @(negedge clock);
    check("drive direction", {31'h0, driveDirection}, {31'h0, dir});
    check("command active", {31'h0, commandActive}, 32'h1);
    apb(1'b1, `PED_CTRL_OFS, 32'h8);
    @(negedge clock);
    check("command stop", {31'h0, commandActive}, 32'h0);
    give_verdict();
  end
endmodule // tb
